// [rtl/sram_defs.svh]
// Shared constants for the pipelined burst memory pin model and its controller
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

`define SRAM_ADDR_W 18
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_DATA_W 32
`define SRAM_BURST_W 2
`define SRAM_BURST_ONE 2'h1
`define SRAM_BURST_ZERO 2'h0
`define SRAM_STRAP_DEFAULT 1'h1

`endif

// [rtl/sram_pkg.sv]
// Types shared by both ends of the memory pin link
`include "sram_defs.svh"

package sram_pkg;

    typedef enum logic [2:0]
    {
        OP_IDLE  = 3'h1,
        OP_READ  = 3'h2,
        OP_WRITE = 3'h4
    } op_t;

    // One lane is the parity bit above its data byte
    typedef logic [`SRAM_LANE_W:0] lane_t;
    typedef lane_t [`SRAM_LANES-1:0] word_t;
    typedef logic [`SRAM_LANES-1:0] lane_mask_t;
    typedef logic [`SRAM_BURST_W-1:0] burst_t;

endpackage

// [rtl/sram_pins_if.sv]
// Pin bundle between the memory device and its controller
`timescale 1ns/10ps
`include "sram_defs.svh"

interface sram_pins_if #(parameter int ADDR_W = `SRAM_ADDR_W);

    logic [ADDR_W-3:0] addr_upper;
    logic addr_bit_one;
    logic addr_bit_zero;
    logic lane0_write_sel_n;
    logic lane1_write_sel_n;
    logic lane2_write_sel_n;
    logic lane3_write_sel_n;
    logic write_strobe_n;
    logic advance_or_load;
    logic clock_qualify_n;
    logic select_low_first;
    logic select_high;
    logic select_low_second;
    logic out_enable_n;
    logic burst_interleaved;
    logic [`SRAM_DATA_W-1:0] dev_dq_o;
    logic [`SRAM_LANES-1:0] dev_parity_o;
    logic dev_dq_oe;
    logic [`SRAM_DATA_W-1:0] ctl_dq_o;
    logic [`SRAM_LANES-1:0] ctl_parity_o;
    logic ctl_dq_oe;
    logic [`SRAM_DATA_W-1:0] dq;
    logic [`SRAM_LANES-1:0] parity_lane;

    // Wire level; an undriven bus reads as zero here
    assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
    assign parity_lane = dev_dq_oe ? dev_parity_o : (ctl_dq_oe ? ctl_parity_o : '0);

    modport dev
    (
        input addr_upper, addr_bit_one, addr_bit_zero,
        input lane0_write_sel_n, lane1_write_sel_n, lane2_write_sel_n, lane3_write_sel_n,
        input write_strobe_n, advance_or_load, clock_qualify_n,
        input select_low_first, select_high, select_low_second,
        input out_enable_n, burst_interleaved, dq, parity_lane,
        output dev_dq_o, dev_parity_o, dev_dq_oe
    );

    modport ctl
    (
        output addr_upper, addr_bit_one, addr_bit_zero,
        output lane0_write_sel_n, lane1_write_sel_n, lane2_write_sel_n, lane3_write_sel_n,
        output write_strobe_n, advance_or_load, clock_qualify_n,
        output select_low_first, select_high, select_low_second,
        output out_enable_n, burst_interleaved,
        output ctl_dq_o, ctl_parity_o, ctl_dq_oe,
        input dq, parity_lane
    );

endinterface

// [rtl/sram_device.sv]
// Pipelined burst memory device end: pin capture, burst counter, array, output gating
`timescale 1ns/10ps
`include "sram_defs.svh"

module sram_device
#(
    parameter int ADDR_W = `SRAM_ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic rst,
    sram_pins_if.dev pins
);
    import sram_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < `SRAM_BURST_W + 1)
    begin : g_bad_width
        $error("Address too narrow for the burst counter");
    end
    if ($bits(pins.addr_upper) != ADDR_W - `SRAM_BURST_W)
    begin : g_bad_bundle
        $error("Pin bundle address width does not match");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic word_t merge_lanes(word_t old_w, word_t new_w, lane_mask_t en);
        word_t res;
        res = old_w;
        for (int i = 0; i < `SRAM_LANES; i++)
        begin
            if (en[i])
            begin
                res[i] = new_w[i];
            end
        end
        return res;
    endfunction

    function automatic burst_t burst_next(burst_t base, burst_t cnt, logic interleaved);
        burst_t res;
        res = interleaved ? (base ^ cnt) : (base + cnt);
        return res;
    endfunction

    // ------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------
    logic take;
    logic sel_now;
    logic [ADDR_W-1:0] addr_pin;
    lane_mask_t lane_en_pin;
    word_t lanes_in;

    assign take = ~pins.clock_qualify_n;
    assign sel_now = ~pins.select_low_first & pins.select_high & ~pins.select_low_second;
    assign addr_pin = {pins.addr_upper, pins.addr_bit_one, pins.addr_bit_zero};
    assign lane_en_pin = ~{pins.lane3_write_sel_n, pins.lane2_write_sel_n,
                           pins.lane1_write_sel_n, pins.lane0_write_sel_n};

    always_comb
    begin
        lanes_in = '0;
        for (int i = 0; i < `SRAM_LANES; i++)
        begin
            lanes_in[i] = {pins.parity_lane[i], pins.dq[i*`SRAM_LANE_W +: `SRAM_LANE_W]};
        end
    end

    // ------------------------------------------------------------
    // Burst order strap
    // ------------------------------------------------------------
    // Caught once after reset; a strap that moves later is not followed
    logic mode_q;
    logic strap_taken_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= `SRAM_STRAP_DEFAULT;
            strap_taken_q <= 1'h0;
        end
        else if (!strap_taken_q)
        begin
            mode_q <= pins.burst_interleaved;
            strap_taken_q <= 1'h1;
        end
    end

    // ------------------------------------------------------------
    // Access stage: command, start address, burst count
    // ------------------------------------------------------------
    op_t a_op_q;
    logic [ADDR_W-1:0] a_addr_q;
    burst_t a_cnt_q;
    lane_mask_t a_en_q;
    logic [ADDR_W-1:0] a_eff;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            a_op_q <= OP_IDLE;
            a_addr_q <= '0;
            a_cnt_q <= `SRAM_BURST_ZERO;
            a_en_q <= '0;
        end
        else if (take)
        begin
            a_en_q <= lane_en_pin;
            if (pins.advance_or_load)
            begin
                // Continues the running access; a deselected link stays idle
                a_cnt_q <= a_cnt_q + `SRAM_BURST_ONE;
            end
            else if (sel_now)
            begin
                a_addr_q <= addr_pin;
                a_cnt_q <= `SRAM_BURST_ZERO;
                a_op_q <= pins.write_strobe_n ? OP_READ : OP_WRITE;
            end
            else
            begin
                a_op_q <= OP_IDLE;
            end
        end
    end

    assign a_eff = {a_addr_q[ADDR_W-1:`SRAM_BURST_W],
                    burst_next(a_addr_q[`SRAM_BURST_W-1:0], a_cnt_q, mode_q)};

    // ------------------------------------------------------------
    // Data stage
    // ------------------------------------------------------------
    op_t b_op_q;
    logic [ADDR_W-1:0] b_addr_q;
    lane_mask_t b_en_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            b_op_q <= OP_IDLE;
            b_addr_q <= '0;
            b_en_q <= '0;
        end
        else if (take)
        begin
            b_op_q <= a_op_q;
            b_addr_q <= a_eff;
            b_en_q <= a_en_q;
        end
    end

    // ------------------------------------------------------------
    // Array
    // ------------------------------------------------------------
    word_t mem [DEPTH];
    logic b_write;

    assign b_write = take && (b_op_q == OP_WRITE);

    // Array contents carry no reset, as in the real part
    always_ff @(posedge clk_sys)
    begin
        if (b_write)
        begin
            mem[b_addr_q] <= merge_lanes(mem[b_addr_q], lanes_in, b_en_q);
        end
    end

    // ------------------------------------------------------------
    // Read output register
    // ------------------------------------------------------------
    word_t rd_q;
    logic drive_q;
    word_t rd_word;

    // A write landing on the same edge is forwarded so the read is not stale
    always_comb
    begin
        rd_word = mem[a_eff];
        if (b_write && (b_addr_q == a_eff))
        begin
            rd_word = merge_lanes(mem[a_eff], lanes_in, b_en_q);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rd_q <= '0;
            drive_q <= 1'h0;
        end
        else if (take)
        begin
            // Only a read may drive; a write data phase or a deselect,
            // from the second cycle after one, leaves the pins free
            drive_q <= (a_op_q == OP_READ);
            if (a_op_q == OP_READ)
            begin
                rd_q <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_comb
    begin
        pins.dev_dq_o = '0;
        pins.dev_parity_o = '0;
        for (int i = 0; i < `SRAM_LANES; i++)
        begin
            pins.dev_dq_o[i*`SRAM_LANE_W +: `SRAM_LANE_W] = rd_q[i][`SRAM_LANE_W-1:0];
            pins.dev_parity_o[i] = rd_q[i][`SRAM_LANE_W];
        end
    end

    // Output enable is asynchronous, so this term is not registered
    assign pins.dev_dq_oe = drive_q & ~pins.out_enable_n;

endmodule

// [rtl/sram_ctrl.sv]
// Controller end: turns user commands into pin cycles and collects read data
`timescale 1ns/10ps
`include "sram_defs.svh"

module sram_ctrl
#(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter bit INTERLEAVED = 1'b1
)
(
    input wire logic clk_sys,
    input wire logic rst,
    sram_pins_if.ctl pins,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_advance,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [`SRAM_DATA_W-1:0] cmd_wdata,
    input wire logic [`SRAM_LANES-1:0] cmd_wparity,
    input wire sram_pkg::lane_mask_t cmd_lane_en,
    input wire logic suspend,
    input wire logic out_enable,
    output logic busy,
    output logic rd_valid,
    output logic [`SRAM_DATA_W-1:0] rd_data,
    output logic [`SRAM_LANES-1:0] rd_parity
);
    import sram_pkg::*;

    if (ADDR_W < `SRAM_BURST_W + 1)
    begin : g_bad_width
        $error("Address too narrow for the burst counter");
    end

    // ------------------------------------------------------------
    // Pin command registers
    // ------------------------------------------------------------
    logic cqn_q;
    logic take;
    op_t p_op_q;
    logic [ADDR_W-1:0] p_addr_q;
    lane_mask_t p_sel_n_q;
    logic p_we_n_q;
    logic p_adv_q;
    logic p_desel_q;
    logic [`SRAM_DATA_W-1:0] p_data_q;
    logic [`SRAM_LANES-1:0] p_par_q;
    logic oen_q;

    // The device only honours an edge while the qualify pin is low
    assign take = ~cqn_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cqn_q <= 1'h1;
            oen_q <= 1'h1;
        end
        else
        begin
            cqn_q <= suspend;
            oen_q <= ~out_enable;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            p_op_q <= OP_IDLE;
            p_addr_q <= '0;
            p_sel_n_q <= '1;
            p_we_n_q <= 1'h1;
            p_adv_q <= 1'h0;
            p_desel_q <= 1'h1;
            p_data_q <= '0;
            p_par_q <= '0;
        end
        else if (take)
        begin
            p_data_q <= cmd_wdata;
            p_par_q <= cmd_wparity;
            // An advance right after a deselect would step nothing useful
            if (cmd_valid && cmd_advance && !p_desel_q)
            begin
                // An advance inherits the op of the command now on the pins
                p_adv_q <= 1'h1;
                p_sel_n_q <= ~cmd_lane_en;
                p_we_n_q <= 1'h1;
            end
            else if (cmd_valid && !cmd_advance)
            begin
                p_op_q <= cmd_write ? OP_WRITE : OP_READ;
                p_addr_q <= cmd_addr;
                p_adv_q <= 1'h0;
                p_desel_q <= 1'h0;
                p_we_n_q <= ~cmd_write;
                p_sel_n_q <= cmd_write ? ~cmd_lane_en : '1;
            end
            else
            begin
                p_op_q <= OP_IDLE;
                p_adv_q <= 1'h0;
                p_desel_q <= 1'h1;
                p_we_n_q <= 1'h1;
                p_sel_n_q <= '1;
            end
        end
    end

    assign pins.addr_upper = p_addr_q[ADDR_W-1:`SRAM_BURST_W];
    assign pins.addr_bit_one = p_addr_q[1];
    assign pins.addr_bit_zero = p_addr_q[0];
    assign pins.lane0_write_sel_n = p_sel_n_q[0];
    assign pins.lane1_write_sel_n = p_sel_n_q[1];
    assign pins.lane2_write_sel_n = p_sel_n_q[2];
    assign pins.lane3_write_sel_n = p_sel_n_q[3];
    assign pins.write_strobe_n = p_we_n_q;
    assign pins.advance_or_load = p_adv_q;
    assign pins.clock_qualify_n = cqn_q;
    assign pins.select_low_first = p_desel_q;
    assign pins.select_high = 1'h1;
    assign pins.select_low_second = 1'h0;
    assign pins.out_enable_n = oen_q;
    assign pins.burst_interleaved = INTERLEAVED;

    // ------------------------------------------------------------
    // Data pipeline, matched to the device's two stages
    // ------------------------------------------------------------
    op_t s1_op_q;
    logic [`SRAM_DATA_W-1:0] s1_data_q;
    logic [`SRAM_LANES-1:0] s1_par_q;
    logic s2_rd_q;
    logic drive_q;
    logic [`SRAM_DATA_W-1:0] dq_q;
    logic [`SRAM_LANES-1:0] par_q;
    logic rd_valid_q;
    logic [`SRAM_DATA_W-1:0] rd_data_q;
    logic [`SRAM_LANES-1:0] rd_par_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s1_op_q <= OP_IDLE;
            s1_data_q <= '0;
            s1_par_q <= '0;
            s2_rd_q <= 1'h0;
            drive_q <= 1'h0;
            dq_q <= '0;
            par_q <= '0;
        end
        else if (take)
        begin
            s1_op_q <= p_op_q;
            s1_data_q <= p_data_q;
            s1_par_q <= p_par_q;
            s2_rd_q <= (s1_op_q == OP_READ);
            drive_q <= (s1_op_q == OP_WRITE);
            dq_q <= s1_data_q;
            par_q <= s1_par_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rd_valid_q <= 1'h0;
            rd_data_q <= '0;
            rd_par_q <= '0;
        end
        else
        begin
            rd_valid_q <= take && s2_rd_q;
            if (take && s2_rd_q)
            begin
                rd_data_q <= pins.dq;
                rd_par_q <= pins.parity_lane;
            end
        end
    end

    assign pins.ctl_dq_o = dq_q;
    assign pins.ctl_parity_o = par_q;
    assign pins.ctl_dq_oe = drive_q;
    assign busy = cqn_q;
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign rd_parity = rd_par_q;

endmodule

// [verif/sram_pins_properties.sv]
// Concurrent checks on the pin bundle between the memory device and its controller
`timescale 1ns/10ps
`include "sram_defs.svh"

module sram_pins_properties
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic write_strobe_n,
    input wire logic advance_or_load,
    input wire logic clock_qualify_n,
    input wire logic select_low_first,
    input wire logic select_high,
    input wire logic select_low_second,
    input wire logic out_enable_n,
    input wire logic [`SRAM_DATA_W-1:0] dev_dq_o,
    input wire logic [`SRAM_LANES-1:0] dev_parity_o,
    input wire logic dev_dq_oe,
    input wire logic ctl_dq_oe
);
    logic sel_ok;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    assign sel_ok = !select_low_first && select_high && !select_low_second;

    // ------------------------------------------------------------
    // Captures seen by the device
    // ------------------------------------------------------------
    sequence s_read_cap;
        !clock_qualify_n && sel_ok && !advance_or_load && write_strobe_n;
    endsequence
    sequence s_write_cap;
        !clock_qualify_n && sel_ok && !advance_or_load && !write_strobe_n;
    endsequence
    sequence s_idle_cap;
        !clock_qualify_n && !sel_ok && !advance_or_load;
    endsequence

    property p_float_oe;
        out_enable_n |-> !dev_dq_oe;
    endproperty
    property p_no_contention;
        !(dev_dq_oe && ctl_dq_oe);
    endproperty
    property p_idle_quiet;
        s_idle_cap ##1 !clock_qualify_n |=> !dev_dq_oe;
    endproperty
    property p_write_quiet;
        s_write_cap ##1 !clock_qualify_n |=> !dev_dq_oe;
    endproperty
    property p_write_data;
        s_write_cap ##1 !clock_qualify_n |=> ctl_dq_oe;
    endproperty
    property p_read_drive;
        s_read_cap ##1 !clock_qualify_n ##1 !out_enable_n |-> dev_dq_oe;
    endproperty
    // Suspended edge leaves the read register untouched
    property p_freeze;
        clock_qualify_n |=> $stable(dev_dq_o) && $stable(dev_parity_o);
    endproperty
    property p_load_after_idle;
        s_idle_cap ##1 !clock_qualify_n |-> !advance_or_load;
    endproperty
    property p_select_tie;
        select_high && !select_low_second;
    endproperty

    a_float_oe: assert property (p_float_oe) else $error("data driven with output enable high");
    a_no_contention: assert property (p_no_contention) else $error("both ends drive data");
    a_idle_quiet: assert property (p_idle_quiet) else $error("data driven after deselect");
    a_write_quiet: assert property (p_write_quiet) else $error("device drives in write data");
    a_write_data: assert property (p_write_data) else $error("write data not presented");
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");
    a_freeze: assert property (p_freeze) else $error("read register moved while held");
    a_load_after_idle: assert property (p_load_after_idle) else $error("advance after idle");
    a_select_tie: assert property (p_select_tie) else $error("static selects wrong");
endmodule

// [verif/testbench.sv]
// Self-checking bench for the memory device and controller joined pin to pin
`timescale 1ns/10ps
`include "sram_defs.svh"

module testbench;
    import sram_pkg::*;

    // Small address space keeps the model array short
    localparam int AW = 6;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_advance = 1'b0;
    logic [AW-1:0] cmd_addr = '0;
    logic [`SRAM_DATA_W-1:0] cmd_wdata = '0;
    logic [`SRAM_LANES-1:0] cmd_wparity = '0;
    lane_mask_t cmd_lane_en = '0;
    logic suspend = 1'b0;
    logic out_enable = 1'b1;
    logic busy;
    logic rd_valid;
    logic [`SRAM_DATA_W-1:0] rd_data;
    logic [`SRAM_LANES-1:0] rd_parity;
    logic [35:0] model [0:2**AW-1];
    logic [35:0] rd_q [$];
    int n_errors = 0;
    int checks_done = 0;

    always #25 clk_sys = ~clk_sys;

    sram_pins_if #(.ADDR_W(AW)) pins ();
    sram_device #(.ADDR_W(AW)) sram_device_inst (.clk_sys(clk_sys), .rst(rst), .pins(pins.dev));
    sram_ctrl #(.ADDR_W(AW), .INTERLEAVED(1'b1)) sram_ctrl_inst
    (
        .clk_sys(clk_sys), .rst(rst), .pins(pins.ctl), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_advance(cmd_advance), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wparity(cmd_wparity), .cmd_lane_en(cmd_lane_en),
        .suspend(suspend), .out_enable(out_enable), .busy(busy), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_parity(rd_parity)
    );
    sram_pins_properties sram_pins_properties_inst
    (
        .clk_sys(clk_sys), .rst(rst), .write_strobe_n(pins.write_strobe_n),
        .advance_or_load(pins.advance_or_load), .clock_qualify_n(pins.clock_qualify_n),
        .select_low_first(pins.select_low_first), .select_high(pins.select_high),
        .select_low_second(pins.select_low_second), .out_enable_n(pins.out_enable_n),
        .dev_dq_o(pins.dev_dq_o), .dev_parity_o(pins.dev_parity_o),
        .dev_dq_oe(pins.dev_dq_oe), .ctl_dq_oe(pins.ctl_dq_oe)
    );

    always @(posedge clk_sys)
    begin
        if (rd_valid === 1'b1)
            rd_q.push_back({rd_parity, rd_data});
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [35:0] pat(input int i);
        return {4'(i + 5), 8'(i), 8'hC3, 8'(i * 3), 8'h5A};
    endfunction

    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Leaves cmd_valid up so back-to-back calls never toggle it
    task automatic cmd(input logic wr, input logic adv, input int a, input logic [35:0] d,
        input lane_mask_t en);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_advance = adv;
        cmd_addr = AW'(a);
        cmd_wdata = d[31:0];
        cmd_wparity = d[35:32];
        cmd_lane_en = en;
        while (busy !== 1'b0) @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
        for (int i = 0; i < 4; i++)
        begin
            if (wr && en[i])
            begin
                model[a][8*i +: 8] = d[8*i +: 8];
                model[a][32+i] = d[32+i];
            end
        end
    endtask

    task automatic idle(input int n);
        cmd_valid = 1'b0;
        repeat (n) @(posedge clk_sys) #1;
    endtask

    task automatic pop(input logic [35:0] exp);
        logic [35:0] got;
        got = 'x;
        if (rd_q.size() > 0)
            got = rd_q.pop_front();
        check("read word", exp, got);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_back_to_back;
        for (int i = 0; i < 4; i++)
            cmd(1'b1, 1'b0, 8 + i, pat(i), 4'hF);
        cmd(1'b0, 1'b0, 11, '0, 4'h0);
        for (int i = 0; i < 4; i++)
            cmd(1'b0, 1'b0, 8 + i, '0, 4'h0);
        idle(8);
        pop(model[11]);
        for (int i = 0; i < 4; i++)
            pop(model[8 + i]);
    endtask

    task automatic t_lanes;
        lane_mask_t masks [3] = '{4'h5, 4'hA, 4'h0};
        cmd(1'b1, 1'b0, 20, 36'hF_FFFF_FFFF, 4'hF);
        for (int k = 0; k < 3; k++)
        begin
            cmd(1'b1, 1'b0, 20, pat(k + 7), masks[k]);
            cmd(1'b0, 1'b0, 20, '0, 4'hF);
            idle(8);
            pop(model[20]);
        end
    endtask

    task automatic t_burst;
        for (int i = 0; i < 4; i++)
            cmd(1'b1, 1'b0, 32 + i, pat(20 + i), 4'hF);
        idle(2);
        cmd(1'b0, 1'b1, 0, '0, 4'h0);
        cmd(1'b0, 1'b0, 33, '0, 4'h0);
        for (int c = 1; c < 4; c++)
            cmd(1'b0, 1'b1, 0, '0, 4'h0);
        idle(8);
        for (int c = 0; c < 4; c++)
            pop(model[32 + (1 ^ c)]);
    endtask

    task automatic t_suspend;
        cmd(1'b0, 1'b0, 9, '0, 4'h0);
        cmd_valid = 1'b0;
        suspend = 1'b1;
        repeat (2) @(posedge clk_sys) #1;
        check("busy", 36'h1, 36'(busy));
        cmd_valid = 1'b1;
        cmd_write = 1'b1;
        cmd_addr = AW'(9);
        cmd_wdata = '0;
        cmd_lane_en = 4'hF;
        repeat (6) @(posedge clk_sys) #1;
        check("reads while held", 36'h0, 36'(rd_q.size()));
        suspend = 1'b0;
        idle(8);
        pop(model[9]);
        cmd(1'b0, 1'b0, 9, '0, 4'h0);
        idle(8);
        pop(model[9]);
    endtask

    task automatic t_oe;
        out_enable = 1'b0;
        idle(2);
        cmd(1'b0, 1'b0, 10, '0, 4'h0);
        idle(8);
        pop(36'h0);
        out_enable = 1'b1;
        idle(2);
        check("reads left over", 36'h0, 36'(rd_q.size()));
    endtask

    task automatic test_done;
        $display("Checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1 rst = 1'b0;
        idle(2);
        t_back_to_back;
        t_lanes;
        t_burst;
        t_suspend;
        t_oe;
        test_done;
    end

    initial
    begin
        #100000;
        n_errors++;
        $display("Error watchdog expected done seen hang");
        test_done;
    end
endmodule
